// ==== hdl/dmc_mode_regs.sv ====
/*
  mode-control register bank of a dual interpolating converter,
  written and read over a serial port on its own clock.
  assumes: clk at 200 MHz, port clock far slower (160 ns period),
  pll_lock from analog logic, bidirectional pins resolved outside.
*/
`timescale 1ns/100ps
`default_nettype none
module dmc_mode_regs
  import dmc_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        reset_n,
  // serial port
  input  wire logic        port_clk,
  input  wire logic        port_select_n,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  output logic             sdo_out,
  output logic             sdo_oe,
  // analog status
  input  wire logic        pll_lock,
  // power and output control
  output logic             i_current_on,
  output logic             q_current_on,
  output logic             digital_enable,
  output logic             analog_enable,
  output logic             resistor_count_mode,
  // filter and modulation
  output logic [1:0]       interp_rate,
  output logic [1:0]       mod_mode,
  output logic             zero_stuff,
  output logic             real_mix,
  output logic             rot_positive,
  // data interface
  output logic             unsigned_data,
  output logic             one_port,
  output logic             sample_clock_strength,
  output logic             sample_clock_out_en,
  // loop and gain
  output logic [1:0]       pll_divide,
  output logic             pll_enable,
  output logic             cp_auto,
  output logic [2:0]       cp_value,
  output logic [dmc_pkg::DATA_W-1:0] in_phase_converter_fine_gain
);
  import dmc_pkg::*;

  logic [DATA_W-1:0] regs_reg [NUM_REGS];
  logic [DATA_W-1:0] regs_next [NUM_REGS];
  logic [DATA_W-1:0] rd_byte_reg, rd_byte_next, rd_value;
  logic              wr_tog_meta, wr_tog_sync, wr_tog_seen;
  logic              rd_tog_meta, rd_tog_sync, rd_tog_seen;
  logic              lock_meta, lock_sync;
  logic              wr_fire, rd_fire, soft_reset;
  logic              wr_toggle, rd_toggle;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] power_r, filter_r, iface_r, div_r, loop_r;

  dmc_spi_link u_link (
    .port_clk      (port_clk),
    .reset_n       (reset_n),
    .port_select_n (port_select_n),
    .sdio_in       (sdio_in),
    .sdio_out      (sdio_out),
    .sdio_oe       (sdio_oe),
    .sdo_out       (sdo_out),
    .sdo_oe        (sdo_oe),
    .cfg_bidir     (power_r[B_BIDIR]),
    .cfg_lsb_first (power_r[B_LSB_FIRST]),
    .rd_byte       (rd_byte_reg),
    .wr_toggle     (wr_toggle),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .rd_toggle     (rd_toggle),
    .rd_addr       (rd_addr)
  );

  // toggles and lock level cross into clk; words stay still meanwhile
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_tog_meta <= 1'b0;
      wr_tog_sync <= 1'b0;
      wr_tog_seen <= 1'b0;
      rd_tog_meta <= 1'b0;
      rd_tog_sync <= 1'b0;
      rd_tog_seen <= 1'b0;
      lock_meta   <= 1'b0;
      lock_sync   <= 1'b0;
    end else begin
      wr_tog_meta <= wr_toggle;
      wr_tog_sync <= wr_tog_meta;
      wr_tog_seen <= wr_tog_sync;
      rd_tog_meta <= rd_toggle;
      rd_tog_sync <= rd_tog_meta;
      rd_tog_seen <= rd_tog_sync;
      lock_meta   <= pll_lock;
      lock_sync   <= lock_meta;
    end
  end

  assign wr_fire    = wr_tog_sync ^ wr_tog_seen;
  assign rd_fire    = rd_tog_sync ^ rd_tog_seen;
  assign soft_reset = wr_fire && wr_addr == A_POWER
                      && wr_data[B_SOFT_RST];

  // register writes; a software reset restores every default
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
      if (soft_reset) begin
        regs_next[i] = reset_val(ADDR_W'(i));
      end else if (wr_fire && wr_addr == ADDR_W'(i)) begin
        regs_next[i] = wr_data & write_mask(ADDR_W'(i));
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regs_reg[0] <= RST_POWER;
      regs_reg[1] <= RST_FILTER;
      regs_reg[2] <= RST_IFACE;
      regs_reg[3] <= RST_DIV;
      regs_reg[4] <= RST_LOOP;
      regs_reg[5] <= RST_GAIN;
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  // read answer; unmapped addresses and unassigned bits give zero
  always_comb begin
    rd_value = 8'h00;
    if (rd_addr < ADDR_W'(NUM_REGS)) begin
      rd_value = regs_reg[rd_addr[2:0]];
    end
    if (rd_addr == A_POWER) begin
      rd_value[B_LOCK] = lock_sync;
    end
    rd_byte_next = rd_fire ? rd_value : rd_byte_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_byte_reg <= 8'h00;
    end else begin
      rd_byte_reg <= rd_byte_next;
    end
  end

  assign power_r = regs_reg[0];
  assign filter_r = regs_reg[1];
  assign iface_r = regs_reg[2];
  assign div_r = regs_reg[3];
  assign loop_r = regs_reg[4];

  // sleep cuts only the output currents; power-down cuts all
  assign i_current_on   = ~power_r[B_SLEEP] & ~power_r[B_PDOWN];
  assign q_current_on   = ~power_r[B_SLEEP] & ~power_r[B_PDOWN];
  assign digital_enable = ~power_r[B_PDOWN];
  assign analog_enable  = ~power_r[B_PDOWN];
  assign resistor_count_mode = power_r[B_ONE_RES];

  assign interp_rate  = filter_r[B_INTERP_HI:B_INTERP_LO];
  assign mod_mode     = filter_r[B_MOD_HI:B_MOD_LO];
  assign zero_stuff   = filter_r[B_ZSTUFF];
  assign real_mix     = filter_r[B_REAL_MIX];
  assign rot_positive = filter_r[B_ROT_POS];

  assign unsigned_data         = iface_r[B_UNSIGNED];
  assign one_port              = iface_r[B_ONE_PORT];
  assign sample_clock_strength = iface_r[B_CLK_DRIVE];
  assign sample_clock_out_en   = ~iface_r[B_EXT_CLK];

  assign pll_divide = div_r[B_DIV_HI:B_DIV_LO];
  assign pll_enable = loop_r[B_PLL_ON];
  assign cp_auto    = ~loop_r[B_CP_MANUAL];
  assign cp_value   = loop_r[B_CP_MANUAL] ? loop_r[B_CP_HI:B_CP_LO]
                                          : 3'h0;
  assign in_phase_converter_fine_gain = regs_reg[5];

  // checks on the register side
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_write_to(logic [ADDR_W-1:0] a);
    wr_fire && wr_addr == a && !soft_reset;
  endsequence

  property p_sleep_currents;
    power_r[B_SLEEP] && !power_r[B_PDOWN] |->
      !i_current_on && !q_current_on && digital_enable && analog_enable;
  endproperty
  a_sleep_currents: assert property (p_sleep_currents)
    else $error("sleep did not cut only the currents");

  property p_power_down;
    s_write_to(A_POWER) ##0 wr_data[B_PDOWN] |=>
      !digital_enable && !analog_enable && !i_current_on;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("power-down write left functions on");

  property p_resistor_mode;
    s_write_to(A_POWER) |=>
      resistor_count_mode == $past(wr_data[B_ONE_RES]);
  endproperty
  a_resistor_mode: assert property (p_resistor_mode)
    else $error("resistor mode did not follow the write");

  property p_rate_modulation;
    s_write_to(A_FILTER) |=>
      interp_rate == $past(wr_data[7:6]) && mod_mode == $past(wr_data[5:4]);
  endproperty
  a_rate_modulation: assert property (p_rate_modulation)
    else $error("rate or modulation did not follow the write");

  property p_zero_stuff;
    s_write_to(A_FILTER) |=> zero_stuff == $past(wr_data[B_ZSTUFF]);
  endproperty
  a_zero_stuff: assert property (p_zero_stuff)
    else $error("zero stuffing did not follow the write");

  property p_mixing;
    s_write_to(A_FILTER) |=> real_mix == $past(wr_data[B_REAL_MIX])
      && rot_positive == $past(wr_data[B_ROT_POS]);
  endproperty
  a_mixing: assert property (p_mixing)
    else $error("mixing mode did not follow the write");

  property p_data_format;
    s_write_to(A_IFACE) |=> unsigned_data == $past(wr_data[B_UNSIGNED])
      && one_port == $past(wr_data[B_ONE_PORT]);
  endproperty
  a_data_format: assert property (p_data_format)
    else $error("data format did not follow the write");

  property p_clock_source;
    s_write_to(A_IFACE) |=>
      sample_clock_out_en == !$past(wr_data[B_EXT_CLK]);
  endproperty
  a_clock_source: assert property (p_clock_source)
    else $error("data clock source did not follow the write");

  property p_loop_control;
    s_write_to(A_LOOP) ##0 wr_data[B_CP_MANUAL] |=>
      pll_enable == $past(wr_data[B_PLL_ON]) && !cp_auto
      && cp_value == $past(wr_data[2:0]);
  endproperty
  a_loop_control: assert property (p_loop_control)
    else $error("loop control did not follow the write");

  property p_reserved_zero;
    rd_fire |=> (rd_byte_reg & ~(write_mask($past(rd_addr))
      | ($past(rd_addr) == A_POWER ? LOCK_MASK : 8'h00))) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unassigned bit read back as one");

  sequence s_unmapped_write;
    wr_fire && wr_addr >= ADDR_W'(NUM_REGS);
  endsequence

  property p_unmapped_ignored;
    s_unmapped_write |=> $stable(power_r) && $stable(filter_r)
      && $stable(iface_r) && $stable(div_r) && $stable(loop_r)
      && $stable(in_phase_converter_fine_gain);
  endproperty
  a_unmapped_ignored: assert property (p_unmapped_ignored)
    else $error("write to an unmapped address changed a register");

  property p_status_bits_clear;
    s_write_to(A_POWER) |=> !power_r[B_LOCK] && !power_r[B_SOFT_RST];
  endproperty
  a_status_bits_clear: assert property (p_status_bits_clear)
    else $error("lock or reset bit was stored by a write");

  property p_power_down_level;
    power_r[B_PDOWN] |-> !digital_enable && !analog_enable
      && !i_current_on && !q_current_on;
  endproperty
  a_power_down_level: assert property (p_power_down_level)
    else $error("power-down left a function running");

endmodule // dmc_mode_regs
`default_nettype wire

// ==== hdl/dmc_pkg.sv ====
/*
  shared constants for the converter mode-control register bank:
  register addresses, field positions, reset values, write masks,
  instruction byte layout and the serial link phase type.
  assumes nothing of its surroundings.
*/
package dmc_pkg;

  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 8;
  localparam int NUM_REGS = 6;

  // register addresses
  localparam logic [ADDR_W-1:0] A_POWER  = 5'h00;
  localparam logic [ADDR_W-1:0] A_FILTER = 5'h01;
  localparam logic [ADDR_W-1:0] A_IFACE  = 5'h02;
  localparam logic [ADDR_W-1:0] A_DIV    = 5'h03;
  localparam logic [ADDR_W-1:0] A_LOOP   = 5'h04;
  localparam logic [ADDR_W-1:0] A_GAIN   = 5'h05;

  // reset values
  localparam logic [DATA_W-1:0] RST_POWER  = 8'h00;
  localparam logic [DATA_W-1:0] RST_FILTER = 8'h04;
  localparam logic [DATA_W-1:0] RST_IFACE  = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIV    = 8'h00;
  localparam logic [DATA_W-1:0] RST_LOOP   = 8'h00;
  localparam logic [DATA_W-1:0] RST_GAIN   = 8'h00;

  // writable bits of each register, and the read-only lock status bit
  localparam logic [DATA_W-1:0] WM_POWER  = 8'hfc;
  localparam logic [DATA_W-1:0] WM_FILTER = 8'hfe;
  localparam logic [DATA_W-1:0] WM_IFACE  = 8'he8;
  localparam logic [DATA_W-1:0] WM_DIV    = 8'h03;
  localparam logic [DATA_W-1:0] WM_LOOP   = 8'hc7;
  localparam logic [DATA_W-1:0] WM_GAIN   = 8'hff;
  localparam logic [DATA_W-1:0] LOCK_MASK = 8'h02;

  // power control fields
  localparam int B_BIDIR     = 7;
  localparam int B_LSB_FIRST = 6;
  localparam int B_SOFT_RST  = 5;
  localparam int B_SLEEP     = 4;
  localparam int B_PDOWN     = 3;
  localparam int B_ONE_RES   = 2;
  localparam int B_LOCK      = 1;
  // filter and modulation fields
  localparam int B_INTERP_HI = 7;
  localparam int B_INTERP_LO = 6;
  localparam int B_MOD_HI    = 5;
  localparam int B_MOD_LO    = 4;
  localparam int B_ZSTUFF    = 3;
  localparam int B_REAL_MIX  = 2;
  localparam int B_ROT_POS   = 1;
  // data interface fields
  localparam int B_UNSIGNED  = 7;
  localparam int B_ONE_PORT  = 6;
  localparam int B_CLK_DRIVE = 5;
  localparam int B_EXT_CLK   = 3;
  // loop fields
  localparam int B_DIV_HI    = 1;
  localparam int B_DIV_LO    = 0;
  localparam int B_PLL_ON    = 7;
  localparam int B_CP_MANUAL = 6;
  localparam int B_CP_HI     = 2;
  localparam int B_CP_LO     = 0;

  // instruction byte fields
  localparam int I_READ   = 7;
  localparam int I_CNT_HI = 6;
  localparam int I_CNT_LO = 5;
  localparam int I_ADR_HI = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    DMC_PH_INSTR,
    DMC_PH_DATA,
    DMC_PH_DONE
  } dmc_phase_t;

  function automatic logic [DATA_W-1:0] reset_val(
    input logic [ADDR_W-1:0] a);
    case (a)
      A_POWER:  reset_val = RST_POWER;
      A_FILTER: reset_val = RST_FILTER;
      A_IFACE:  reset_val = RST_IFACE;
      A_DIV:    reset_val = RST_DIV;
      A_LOOP:   reset_val = RST_LOOP;
      A_GAIN:   reset_val = RST_GAIN;
      default:  reset_val = 8'h00;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] write_mask(
    input logic [ADDR_W-1:0] a);
    case (a)
      A_POWER:  write_mask = WM_POWER;
      A_FILTER: write_mask = WM_FILTER;
      A_IFACE:  write_mask = WM_IFACE;
      A_DIV:    write_mask = WM_DIV;
      A_LOOP:   write_mask = WM_LOOP;
      A_GAIN:   write_mask = WM_GAIN;
      default:  write_mask = 8'h00;
    endcase
  endfunction

endpackage

// ==== hdl/dmc_spi_link.sv ====
/*
  serial port engine, clocked by the port clock.
  assumes: port clock edges only inside frames; the register side
  answers a read request within half a port clock period and holds
  rd_byte stable; cfg inputs come from the system clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module dmc_spi_link
  import dmc_pkg::*;
(
  // link pins
  input  wire logic                      port_clk,
  input  wire logic                      reset_n,
  input  wire logic                      port_select_n,
  input  wire logic                      sdio_in,
  output logic                           sdio_out,
  output logic                           sdio_oe,
  output logic                           sdo_out,
  output logic                           sdo_oe,
  // settings from the register side
  input  wire logic                      cfg_bidir,
  input  wire logic                      cfg_lsb_first,
  input  wire logic [dmc_pkg::DATA_W-1:0] rd_byte,
  // handoff to the register side
  output logic                           wr_toggle,
  output logic [dmc_pkg::ADDR_W-1:0]     wr_addr,
  output logic [dmc_pkg::DATA_W-1:0]     wr_data,
  output logic                           rd_toggle,
  output logic [dmc_pkg::ADDR_W-1:0]     rd_addr
);
  import dmc_pkg::*;

  logic              frame_rst_n;
  logic              bidir_meta, bidir_sync, lsb_meta, lsb_sync;
  dmc_phase_t        phase_reg, phase_next;
  logic [2:0]        bit_cnt_reg, bit_cnt_next;
  logic [7:0]        shift_reg, shift_next, rx_byte;
  logic              is_read_reg, is_read_next;
  logic [1:0]        left_reg, left_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              wr_toggle_next, rd_toggle_next;
  logic [ADDR_W-1:0] wr_addr_next, rd_addr_next;
  logic [DATA_W-1:0] wr_data_next;
  logic [7:0]        tx_reg, tx_next;
  logic              out_reg, out_next, read_drive;

  // chip select high clears the frame logic at once
  assign frame_rst_n = reset_n & ~port_select_n;

  // settings cross into the port clock domain
  always_ff @(posedge port_clk or negedge reset_n) begin
    if (!reset_n) begin
      bidir_meta <= 1'b0;
      bidir_sync <= 1'b0;
      lsb_meta   <= 1'b0;
      lsb_sync   <= 1'b0;
    end else begin
      bidir_meta <= cfg_bidir;
      bidir_sync <= bidir_meta;
      lsb_meta   <= cfg_lsb_first;
      lsb_sync   <= lsb_meta;
    end
  end

  // input bits are taken on the rising edge
  assign rx_byte = lsb_sync ? {sdio_in, shift_reg[7:1]}
                            : {shift_reg[6:0], sdio_in};

  always_comb begin
    phase_next     = phase_reg;
    bit_cnt_next   = bit_cnt_reg + 3'h1;
    shift_next     = rx_byte;
    is_read_next   = is_read_reg;
    left_next      = left_reg;
    addr_next      = addr_reg;
    wr_toggle_next = wr_toggle;
    wr_addr_next   = wr_addr;
    wr_data_next   = wr_data;
    rd_toggle_next = rd_toggle;
    rd_addr_next   = rd_addr;
    case (phase_reg)
      DMC_PH_INSTR: begin
        if (bit_cnt_reg == LAST_BIT) begin
          is_read_next = rx_byte[I_READ];
          left_next    = rx_byte[I_CNT_HI:I_CNT_LO];
          addr_next    = rx_byte[I_ADR_HI:0];
          phase_next   = DMC_PH_DATA;
          if (rx_byte[I_READ]) begin
            rd_addr_next   = rx_byte[I_ADR_HI:0];
            rd_toggle_next = ~rd_toggle;
          end
        end
      end
      DMC_PH_DATA: begin
        if (bit_cnt_reg == LAST_BIT) begin
          addr_next = addr_reg + 5'h01;
          left_next = left_reg - 2'h1;
          if (!is_read_reg) begin
            wr_addr_next   = addr_reg;
            wr_data_next   = rx_byte;
            wr_toggle_next = ~wr_toggle;
          end
          if (left_reg == 2'h0) begin
            phase_next = DMC_PH_DONE;
          end else if (is_read_reg) begin
            rd_addr_next   = addr_reg + 5'h01;
            rd_toggle_next = ~rd_toggle;
          end
        end
      end
      DMC_PH_DONE: begin
        bit_cnt_next = bit_cnt_reg;
      end
      default: begin
        phase_next = DMC_PH_INSTR;
      end
    endcase
  end

  always_ff @(posedge port_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase_reg   <= DMC_PH_INSTR;
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
      is_read_reg <= 1'b0;
      left_reg    <= 2'h0;
      addr_reg    <= 5'h00;
    end else begin
      phase_reg   <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      is_read_reg <= is_read_next;
      left_reg    <= left_next;
      addr_reg    <= addr_next;
    end
  end

  // handoff words survive chip select so no false toggle is seen
  always_ff @(posedge port_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_toggle <= 1'b0;
      wr_addr   <= 5'h00;
      wr_data   <= 8'h00;
      rd_toggle <= 1'b0;
      rd_addr   <= 5'h00;
    end else begin
      wr_toggle <= wr_toggle_next;
      wr_addr   <= wr_addr_next;
      wr_data   <= wr_data_next;
      rd_toggle <= rd_toggle_next;
      rd_addr   <= rd_addr_next;
    end
  end

  // output bits are launched on the falling edge
  always_comb begin
    tx_next  = tx_reg;
    out_next = out_reg;
    if (phase_reg == DMC_PH_DATA && is_read_reg) begin
      if (bit_cnt_reg == 3'h0) begin
        out_next = lsb_sync ? rd_byte[0] : rd_byte[7];
        tx_next  = lsb_sync ? {1'b0, rd_byte[7:1]}
                            : {rd_byte[6:0], 1'b0};
      end else begin
        out_next = lsb_sync ? tx_reg[0] : tx_reg[7];
        tx_next  = lsb_sync ? {1'b0, tx_reg[7:1]}
                            : {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge port_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_reg  <= 8'h00;
      out_reg <= 1'b0;
    end else begin
      tx_reg  <= tx_next;
      out_reg <= out_next;
    end
  end

  // the read pin is sdio only when bidirectional mode is on
  assign read_drive = (phase_reg == DMC_PH_DATA) && is_read_reg;
  assign sdio_out   = out_reg;
  assign sdo_out    = out_reg;
  assign sdio_oe    = read_drive & bidir_sync;
  assign sdo_oe     = read_drive & ~bidir_sync;

  property p_sdio_input_only;
    @(posedge port_clk) disable iff (!frame_rst_n)
    !bidir_sync && phase_reg == DMC_PH_DATA && is_read_reg
      |-> !sdio_oe && sdo_oe;
  endproperty
  a_sdio_input_only: assert property (p_sdio_input_only)
    else $error("sdio driven while bidirectional mode is off");

endmodule // dmc_spi_link
`default_nettype wire

// ==== sim/dmc_spi_host.sv ====
/*
  serial host model: runs the port clock only inside frames, shifts
  in either bit order and returns each read byte with a done flag.
  assumes the bank is out of reset before frame() is called.
*/
`timescale 1ns/100ps
`default_nettype none
module dmc_spi_host (
  // link pins
  output logic       port_clk,
  output logic       port_select_n,
  output logic       sdio_in,
  input  wire logic  sdio_out,
  input  wire logic  sdio_oe,
  input  wire logic  sdo_out,
  input  wire logic  sdo_oe,
  // read result
  output logic [7:0] rd_data,
  output logic       rd_done
);
  logic drv;
  assign sdio_in = sdio_oe ? sdio_out : drv;
  initial begin
    port_clk = 1'b0;
    port_select_n = 1'b1;
    rd_done = 1'b0;
    rd_data = 8'h00;
    drv = 1'b0;
  end
  // a short nb aborts the frame part way
  task automatic frame(input logic [15:0] w, input int nb,
                       input logic lsb);
    int i, k;
    #37;
    port_select_n = 1'b0;
    for (i = 0; i < nb; i++) begin
      // bit index within each byte follows the chosen order
      k = lsb ? ((i < 8) ? i + 8 : i - 8) : 15 - i;
      // a released line toggles so stale data never looks valid
      drv = (i > 7 && w[15]) ? ~drv : w[k];
      #80 port_clk = 1'b1;
      if (i > 7)
        rd_data[k] = (sdo_oe ^ sdio_oe) ?
                     (sdo_oe ? sdo_out : sdio_out) : drv;
      #80 port_clk = 1'b0;
    end
    #80 port_select_n = 1'b1;
    rd_done = w[15] && nb == 16;
    #80 rd_done = 1'b0;
  endtask
endmodule // dmc_spi_host
`default_nettype wire

// ==== sim/tb_dmc_mode_regs.sv ====
/*
  self-checking bench for the mode-control bank: a host model writes
  and reads the registers, read bytes are scored from a queue.
  assumes the package, the bank and the host model compile first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_dmc_mode_regs;
  import dmc_pkg::*;
  logic       clk, reset_n, pll_lock, port_clk, port_select_n, sdio_in;
  logic       sdio_out, sdio_oe, sdo_out, sdo_oe, rd_done;
  logic       i_on, q_on, d_en, a_en, res1, zs, rmix, rot;
  logic       uns, onep, strength, clk_en, pll_en, cp_auto, lsb_mode;
  logic [1:0] interp, modm, pdiv;
  logic [2:0] cp_val;
  logic [7:0] gain, rd_data, rnd, e;
  logic [7:0] exp_q[$];
  logic [7:0] wm[6];
  logic [15:0] pw[3];
  int         n_mismatch, checked;

  dmc_mode_regs uut (.clk(clk), .reset_n(reset_n), .port_clk(port_clk),
    .port_select_n(port_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .pll_lock(pll_lock), .i_current_on(i_on), .q_current_on(q_on),
    .digital_enable(d_en), .analog_enable(a_en),
    .resistor_count_mode(res1), .interp_rate(interp), .mod_mode(modm),
    .zero_stuff(zs), .real_mix(rmix), .rot_positive(rot),
    .unsigned_data(uns), .one_port(onep),
    .sample_clock_strength(strength), .sample_clock_out_en(clk_en),
    .pll_divide(pdiv), .pll_enable(pll_en), .cp_auto(cp_auto),
    .cp_value(cp_val), .in_phase_converter_fine_gain(gain));
  dmc_spi_host host (.port_clk(port_clk), .port_select_n(port_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .rd_data(rd_data),
    .rd_done(rd_done));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // register image rebuilt from the decoded outputs
  function automatic logic [7:0] seen(input int a);
    case (a)
      0: return {i_on, q_on, d_en, a_en, res1, 3'h0};
      1: return {interp, modm, zs, rmix, rot, 1'b0};
      2: return {uns, onep, strength, 1'b0, ~clk_en, 3'h0};
      3: return {6'h00, pdiv};
      4: return {pll_en, ~cp_auto, 3'h0, cp_val};
      default: return gain;
    endcase
  endfunction

  task automatic check(input logic [7:0] s, input logic [7:0] x,
                       input string what);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, x, s);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk) #1 host.frame({3'b000, a, d}, 16, lsb_mode);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    @(posedge clk) #1 host.frame({3'b100, a, 8'h00}, 16, lsb_mode);
  endtask

  always @(posedge rd_done) check(rd_data, exp_q.pop_front(), "read");

  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end

  initial begin
    reset_n = 1'b0;
    pll_lock = 1'b0;
    rnd = 8'h2f;
    lsb_mode = 1'b0;
    n_mismatch = 0;
    checked = 0;
    wm = '{WM_POWER, WM_FILTER, WM_IFACE, WM_DIV, WM_LOOP, WM_GAIN};
    pw = '{16'h1030, 16'h0800, 16'h04f8};
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    check(seen(0), 8'hf0, "power outs");
    for (int a = 0; a < 7; a++) begin
      e = (a == 1) ? RST_FILTER : 8'h00;
      if (a > 0) check(seen(a), e, "reset outs");
      rd(a[4:0], e);
    end
    $display("test reset done");
    repeat (3)
      for (int a = 1; a < 6; a++) begin
        rnd = lfsr(rnd);
        e = rnd & wm[a];
        wr(a[4:0], rnd);
        check(seen(a), (a == 4 && !e[6]) ? e & 8'hf8 : e, "outs");
        rd(a[4:0], e);
      end
    $display("test random done");
    foreach (pw[k]) begin
      wr(5'h00, pw[k][15:8]);
      check(seen(0), pw[k][7:0], "power outs");
      rd(5'h00, pw[k][15:8]);
    end
    @(posedge clk) #1 pll_lock = 1'b1;
    rd(5'h00, 8'h06);
    $display("test power done");
    wr(5'h00, 8'h80);
    rd(5'h05, e);
    wr(5'h00, 8'h00);
    wr(5'h01, 8'hf8);
    wr(5'h00, 8'h20);
    rd(5'h01, RST_FILTER);
    rd(5'h00, 8'h02);
    $display("test bidir and soft reset done");
    wr(5'h00, 8'h40);
    // two port clock rises let the order setting settle
    @(posedge clk) #1 host.frame(16'h0000, 2, lsb_mode);
    lsb_mode = 1'b1;
    wr(5'h03, 8'h01);
    check(seen(3), 8'h01, "lsb outs");
    rd(5'h03, 8'h01);
    wr(5'h00, 8'h00);
    lsb_mode = 1'b0;
    @(posedge clk) #1 host.frame(16'h0000, 2, lsb_mode);
    $display("test lsb first done");
    @(posedge clk) #1 host.frame(16'h01aa, 4, lsb_mode);
    wr(5'h01, 8'h30);
    rd(5'h01, 8'h30);
    wr(5'h06, 8'hff);
    rd(5'h06, 8'h00);
    check({7'h00, exp_q.size() == 0}, 8'h01, "queue");
    $display("test abort and unmapped done");
    test_done();
  end
endmodule // tb_dmc_mode_regs
`default_nettype wire
